// ===== rtl/sba_pkg.sv
// Operation
// - Quad-byte add sums each byte lane of both sources independently.
// - Wrapping quad-byte add keeps each lane sum modulo 256.
// - Saturating quad-byte add clamps overflowing lanes to 0xff.
// - Any lane carry in either quad-byte add sets overflow bit 20.
// - Lane results keep their byte position in the destination word.
// - Add-with-carry writes low 32 bits of a plus b plus carry bit 13.
// - Add-with-carry sets bit 20 when sum bits 32 and 31 differ.
// - Add-with-carry decodes from function 1111000101, bit 10 zero.
// - Halving add shifts each 9-bit lane sum right by one.
// - Rounding halving add adds one before the shift.
// - Halving adds never change the control register.
// - Append shifts target left by shift amount, filling from source a low bits.
// - Append decodes from function 1000010101, shift amount in bits 15 to 11.
// - No operand-dependent exceptions; overflow only via the flag.
// - Add-with-carry raises reserved-instruction if absent, disabled if disabled.
package sba_pkg;
   localparam logic [5:0] MAJOR_OPCODE_GROUP = 6'h00;
   localparam logic [10:0] FN_QB_ADD_WRAP = 11'h0cd;
   localparam logic [10:0] FN_QB_ADD_SAT = 11'h4cd;
   localparam logic [10:0] FN_QB_HADD = 11'h14d;
   localparam logic [10:0] FN_QB_HADD_RND = 11'h54d;
   localparam logic [9:0] FN_WORD_ADDC = 10'h3c5;
   localparam logic [9:0] FN_APPEND = 10'h215;
   localparam int CTL_CARRY_BIT = 13;
   localparam int CTL_OUFLAG_BIT = 20;
   localparam logic [31:0] CTL_RESET = 32'h0000_0000;

   typedef struct packed {
      logic valid;
      logic [31:0] instr;
      logic [31:0] src_a;
      logic [31:0] src_b;
   } sba_req_t;

   typedef struct packed {
      logic valid;
      logic [4:0] dest;
      logic [31:0] data;
      logic exc_reserved;
      logic exc_disabled;
   } sba_rsp_t;
endpackage

// ===== rtl/sba_alu.sv
module sba_alu (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire sba_pkg::sba_req_t req,
   input wire logic module_present,
   input wire logic module_enable,
   output sba_pkg::sba_rsp_t rsp,
   output logic [31:0] ctl_reg
);
   typedef enum {SBA_NONE, SBA_WRAP, SBA_SAT, SBA_HADD, SBA_HRND, SBA_ADDC, SBA_APP} sba_op_t;

   function automatic sba_op_t sba_decode(input logic [31:0] ins);
      sba_op_t op;
      op = SBA_NONE;
      if (ins[31:26] == sba_pkg::MAJOR_OPCODE_GROUP) begin
         if (ins[10:0] == sba_pkg::FN_QB_ADD_WRAP) op = SBA_WRAP;
         else if (ins[10:0] == sba_pkg::FN_QB_ADD_SAT) op = SBA_SAT;
         else if (ins[10:0] == sba_pkg::FN_QB_HADD) op = SBA_HADD;
         else if (ins[10:0] == sba_pkg::FN_QB_HADD_RND) op = SBA_HRND;
         else if (ins[10] == 1'b0 && ins[9:0] == sba_pkg::FN_WORD_ADDC) op = SBA_ADDC;
         else if (ins[10] == 1'b0 && ins[9:0] == sba_pkg::FN_APPEND) op = SBA_APP;
      end
      return op;
   endfunction

   sba_op_t op;
   logic [31:0] res;
   logic lane_carry;
   logic [32:0] wsum;
   logic [4:0] sh;
   logic [31:0] app_mask;
   logic [8:0] lsum [4];
   logic [8:0] lsum_rnd [4];
   logic [31:0] wrap_w, sat_w, hadd_w, hrnd_w;
   logic [3:0] carries;

   sba_pkg::sba_rsp_t rsp_nxt;
   logic [31:0] ctl_nxt;
   sba_pkg::sba_rsp_t rsp_r;
   logic [31:0] ctl_r;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : lane
         assign lsum[g] = {1'b0, req.src_a[8*g +: 8]} + {1'b0, req.src_b[8*g +: 8]};
         assign lsum_rnd[g] = lsum[g] + 9'h001;
         assign carries[g] = lsum[g][8];
         assign wrap_w[8*g +: 8] = lsum[g][7:0];
         assign sat_w[8*g +: 8] = lsum[g][8] ? 8'hff : lsum[g][7:0];
         assign hadd_w[8*g +: 8] = lsum[g][8:1];
         assign hrnd_w[8*g +: 8] = lsum_rnd[g][8:1];
      end
   endgenerate

   always_comb begin
      op = req.valid ? sba_decode(req.instr) : SBA_NONE;
      lane_carry = |carries;
      wsum = {req.src_a[31], req.src_a} + {req.src_b[31], req.src_b}
             + {32'h0000_0000, ctl_r[sba_pkg::CTL_CARRY_BIT]};
      sh = req.instr[15:11];
      app_mask = ~(32'hffff_ffff << sh);
      res = 32'h0000_0000;
      ctl_nxt = ctl_r;
      rsp_nxt = '0;
      rsp_nxt.valid = op != SBA_NONE;
      rsp_nxt.dest = req.instr[15:11];
      unique case (op)
         SBA_NONE: res = 32'h0000_0000;
         SBA_WRAP: res = wrap_w;
         SBA_SAT: res = sat_w;
         SBA_HADD: res = hadd_w;
         SBA_HRND: res = hrnd_w;
         SBA_ADDC: res = wsum[31:0];
         SBA_APP: begin
            // Zero shift leaves target as is, mask empty
            res = (req.src_b << sh) | (req.src_a & app_mask);
            rsp_nxt.dest = req.instr[25:21];
         end
      endcase
      if (op == SBA_ADDC && !module_present) begin
         rsp_nxt.exc_reserved = 1'b1;
      end else if (op == SBA_ADDC && !module_enable) begin
         rsp_nxt.exc_disabled = 1'b1;
      end else begin
         if ((op == SBA_WRAP || op == SBA_SAT) && lane_carry)
            ctl_nxt[sba_pkg::CTL_OUFLAG_BIT] = 1'b1;
         if (op == SBA_ADDC && wsum[32] != wsum[31])
            ctl_nxt[sba_pkg::CTL_OUFLAG_BIT] = 1'b1;
         rsp_nxt.data = res;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rsp_r <= '0;
         ctl_r <= sba_pkg::CTL_RESET;
      end else begin
         rsp_r <= rsp_nxt;
         ctl_r <= ctl_nxt;
      end
   end

   assign rsp = rsp_r;
   assign ctl_reg = ctl_r;

   sticky_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $past(ctl_r[sba_pkg::CTL_OUFLAG_BIT]) |-> ctl_r[sba_pkg::CTL_OUFLAG_BIT])
      else $error("overflow flag cleared");
   halving_ctl_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (op == SBA_HADD || op == SBA_HRND) |=> $stable(ctl_r))
      else $error("halving add changed control");
   wrap_carry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (op == SBA_WRAP && lane_carry) |=> ctl_r[sba_pkg::CTL_OUFLAG_BIT])
      else $error("lane carry not flagged");
   sat_carry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (op == SBA_SAT && lane_carry) |=> ctl_r[sba_pkg::CTL_OUFLAG_BIT])
      else $error("saturating carry not flagged");
   sat_lane_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (op == SBA_SAT && carries[0]) |=> rsp_r.data[7:0] == 8'hff)
      else $error("saturation missing");
   addc_result_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (op == SBA_ADDC && module_present && module_enable) |=>
      rsp_r.data == $past(req.src_a) + $past(req.src_b)
         + {31'h0, $past(ctl_r[sba_pkg::CTL_CARRY_BIT])})
      else $error("add with carry wrong");
   addc_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (op == SBA_ADDC && module_present && module_enable && wsum[32] != wsum[31])
      |=> ctl_r[sba_pkg::CTL_OUFLAG_BIT])
      else $error("word overflow not flagged");
   addc_absent_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (op == SBA_ADDC && !module_present) |=> rsp_r.exc_reserved && $stable(ctl_r))
      else $error("reserved exception missing");
   addc_disabled_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (op == SBA_ADDC && module_present && !module_enable)
      |=> rsp_r.exc_disabled && !rsp_r.exc_reserved && $stable(ctl_r))
      else $error("disabled exception missing");
   no_data_exc_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (op != SBA_ADDC) |=> !rsp_r.exc_reserved && !rsp_r.exc_disabled)
      else $error("exception on plain arithmetic");
   append_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (op == SBA_APP && sh == 5'h00) |=> rsp_r.data == $past(req.src_b))
      else $error("zero append changed target");
   append_dest_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (op == SBA_APP) |=> rsp_r.dest == $past(req.instr[25:21]))
      else $error("append written to wrong register");
   decode_addc_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (req.valid && req.instr[31:26] == sba_pkg::MAJOR_OPCODE_GROUP
         && req.instr[10:0] == {1'b0, sba_pkg::FN_WORD_ADDC}) |-> op == SBA_ADDC)
      else $error("add with carry not decoded");
   decode_app_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (req.valid && req.instr[31:26] == sba_pkg::MAJOR_OPCODE_GROUP
         && req.instr[10:0] == {1'b0, sba_pkg::FN_APPEND}) |-> op == SBA_APP)
      else $error("append not decoded");
   idle_rsp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !req.valid |=> !rsp_r.valid)
      else $error("response without request");

   // Per-lane result checks, one copy for each byte
   generate
      for (g = 0; g < 4; g++) begin : lane_chk
         wrap_lane_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
            (op == SBA_WRAP) |=> rsp_r.data[8*g +: 8]
               == 8'($past(req.src_a[8*g +: 8]) + $past(req.src_b[8*g +: 8])))
            else $error("wrapping lane wrong");
         sat_each_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
            (op == SBA_SAT && carries[g]) |=> rsp_r.data[8*g +: 8] == 8'hff)
            else $error("saturating lane not clamped");
         hadd_lane_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
            (op == SBA_HADD) |=> rsp_r.data[8*g +: 8]
               == 8'(({1'b0, $past(req.src_a[8*g +: 8])}
               + {1'b0, $past(req.src_b[8*g +: 8])}) >> 1))
            else $error("halving lane wrong");
         hrnd_lane_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
            (op == SBA_HRND) |=> rsp_r.data[8*g +: 8]
               == 8'(({1'b0, $past(req.src_a[8*g +: 8])}
               + {1'b0, $past(req.src_b[8*g +: 8])} + 9'h001) >> 1))
            else $error("rounding lane wrong");
      end
   endgenerate
endmodule

// ===== tb/sba_pipe_model.sv
module sba_pipe_model (
   input wire logic ref_clk,
   output sba_pkg::sba_req_t req
);
   timeunit 1ns;
   timeprecision 1ns;
   initial req = '0;
   // One request per edge, launched just after it
   task automatic issue(input logic v, input logic [31:0] i, a, b);
      @(posedge ref_clk);
      #1;
      req <= {v, i, a, b};
   endtask
endmodule

// ===== tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0;
   logic sys_rst = 1;
   logic mp, me, ev, eov, ov, nmp, nme;
   logic [31:0] ctl, ed, a, b, i;
   logic [31:0] s = 32'hc2f68890;
   logic [32:0] w;
   logic [10:0] fns [6];
   logic [4:0] edst;
   logic [1:0] ex;
   int t, op;
   int n_fail = 0;
   int samples_checked = 0;
   sba_pkg::sba_req_t req;
   sba_pkg::sba_rsp_t rsp;
   sba_alu DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .module_present(mp),
      .module_enable(me), .rsp(rsp), .ctl_reg(ctl));
   sba_pipe_model pipe (.ref_clk(ref_clk), .req(req));
   initial forever #50 ref_clk = ~ref_clk;
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(string nm, logic [32:0] e, logic [32:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic end_sim;
      if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      end_sim;
   end
   initial begin
      fns = '{sba_pkg::FN_QB_ADD_WRAP, sba_pkg::FN_QB_ADD_SAT, sba_pkg::FN_QB_HADD,
         sba_pkg::FN_QB_HADD_RND, {1'b0, sba_pkg::FN_WORD_ADDC}, {1'b0, sba_pkg::FN_APPEND}};
      mp = 1;
      me = 1;
      ev = 0;
      eov = 0;
      repeat (16) @(posedge ref_clk);
      #1 sys_rst = 0;
      for (int n = 0; n < 400; n++) begin
         // Mid-run reset re-arms the sticky flag
         if (n % 50 == 49) begin
            pipe.issue(0, s, a, b);
            sys_rst = 1;
            @(posedge ref_clk);
            #1 sys_rst = 0;
            ev = 0;
            eov = 0;
         end
         s = lfsr(s);
         a = s;
         s = lfsr(s);
         b = s;
         s = lfsr(s);
         op = s % 7;
         nmp = s[3] | s[4];
         nme = s[5] | s[6];
         i = {6'h00, s[25:11], op == 6 ? 11'h7ff : fns[op]};
         pipe.issue(1, i, a, b);
         // Unit state moves together with the request it qualifies
         mp = nmp;
         me = nme;
         chk("valid", ev, rsp.valid);
         if (ev) begin
            chk("data", ed, rsp.data);
            chk("dest", edst, rsp.dest);
            chk("exc", ex, {rsp.exc_reserved, rsp.exc_disabled});
         end
         chk("ctl", {eov, 20'h00000}, ctl);
         ev = op != 6;
         ed = 0;
         ex = 0;
         ov = 0;
         edst = op == 5 ? i[25:21] : i[15:11];
         for (int l = 0; l < 4; l++) begin
            t = a[8*l+:8] + b[8*l+:8];
            ov |= op < 2 && t > 255;
            ed[8*l+:8] = 8'(op == 1 && t > 255 ? 255 : op == 2 ? t / 2 : op == 3 ? (t + 1) / 2 : t);
         end
         // Carry bit stays clear: nothing here loads it
         w = {a[31], a} + {b[31], b};
         if (op == 4) begin
            ex = {!mp, mp & !me};
            ed = ex != 0 ? 0 : w[31:0];
            ov = ex == 0 && w[32] != w[31];
         end
         if (op == 5) ed = i[15:11] == 0 ? b : (b << i[15:11]) | (a & ((32'h1 << i[15:11]) - 1));
         eov |= ov;
      end
      pipe.issue(0, 0, 0, 0);
      chk("valid", ev, rsp.valid);
      chk("data", ev ? ed : 32'h0000_0000, rsp.data);
      chk("ctl", {eov, 20'h00000}, ctl);
      end_sim;
   end
endmodule
